//--- core/vcr_defs.svh
// Notes on behaviour
// - Capability bit 15 reads REJECT_SNOOP, 0 by default, so VC0 then allows snooped and no-snoop TLPs.
// - If snoop reject is 1, TLPs without No Snoop are Unsupported Requests.
// - Control bit 31, the default channel enable, is fixed at 1 and read-only.
// - Control bits 26:24, the channel identifier, are read-only and zero.
// - Map bits 7:1 are read-write, reset to ones, bit n routes class n.
// - Several map bits may be set at once, each marked class rides VC0.
// - Control bit 0 is read-only and reads 1, so class zero goes to VC0.
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH

// Register offsets in extended configuration space
`define VCR_CAP_OFS 12'h110
`define VCR_CTL_OFS 12'h114

// Reset values
`define VCR_CAP_RST 32'h0000_0000
`define VCR_CTL_RST 32'h8000_00FF
`define VCR_MAP_RST 7'h7F

// Field positions
`define VCR_RSNP_BIT 15
`define VCR_EN_BIT 31
`define VCR_ID_LSB 24
`define VCR_ID_MSB 26
`define VCR_MAP_LSB 1
`define VCR_MAP_MSB 7
`define VCR_TC0_BIT 0
`define VCR_ID_VAL 3'h0
`define VCR_MAP_BE 0

`endif

//--- core/vcr_map_if.sv
interface vcr_map_if;
    import vcr_pkg::*;
    vcr_tc_map_t tc_map;
    logic reject_snoop;
    logic tlp_valid;
    vcr_tc_t tlp_tc;
    logic tlp_no_snoop;
    vcr_verdict_t verdict;
    // Register side drives map and request, reads verdict
    modport regs (output tc_map, reject_snoop, tlp_valid, tlp_tc,
                  output tlp_no_snoop, input verdict);
    // Steering side judges each request
    modport steer (input tc_map, reject_snoop, tlp_valid, tlp_tc,
                   input tlp_no_snoop, output verdict);
endinterface

//--- core/vcr_pkg.sv
package vcr_pkg;
    // Register port widths
    typedef logic [11:0] vcr_addr_t;
    typedef logic [31:0] vcr_word_t;
    typedef logic [3:0] vcr_be_t;
    // Traffic class label and its full class map
    typedef logic [2:0] vcr_tc_t;
    typedef logic [7:0] vcr_tc_map_t;
    // Verdict on one transaction
    typedef enum logic [1:0]
    {
        VCR_NONE = 2'b00,
        VCR_ACCEPT = 2'b01,
        VCR_UNSUPP = 2'b10,
        VCR_UNMAPPED = 2'b11
    } vcr_verdict_t;
endpackage

//--- core/vcr_regs.sv
`include "vcr_defs.svh"

module vcr_regs
#(
    parameter bit REJECT_SNOOP = 1'b0
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire vcr_pkg::vcr_addr_t cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire vcr_pkg::vcr_be_t cfg_be_i,
    input wire vcr_pkg::vcr_word_t cfg_wdata_i,
    output logic cfg_rvalid_o,
    output vcr_pkg::vcr_word_t cfg_rdata_o,
    input wire logic tlp_valid_i,
    input wire vcr_pkg::vcr_tc_t tlp_tc_i,
    input wire logic tlp_no_snoop_i,
    output logic tlp_accept_o,
    output logic tlp_unsupp_o,
    output logic tlp_unmapped_o,
    output vcr_pkg::vcr_tc_map_t tc_map_o
);
    import vcr_pkg::*;

    logic [`VCR_MAP_MSB:`VCR_MAP_LSB] traffic_class_map_q;
    logic [`VCR_MAP_MSB:`VCR_MAP_LSB] traffic_class_map_d;
    vcr_word_t rdata_q;
    vcr_word_t rdata_d;
    logic rvalid_q;
    logic accept_q;
    logic unsupp_q;
    logic unmapped_q;
    vcr_tc_map_t tc_map_q;

    wire cap_hit;
    wire ctl_hit;
    wire map_wr;
    wire reject_snooped_traffic_flag;
    wire default_channel_enable_bit;
    wire [2:0] default_channel_identifier;
    wire class_zero_fixed_map_bit;
    wire [6:0] wdata_map;
    vcr_word_t cap_word;
    vcr_word_t ctl_word;
    vcr_tc_map_t full_map;

    vcr_map_if map_if ();

    // Address decode
    assign cap_hit = (cfg_addr_i == `VCR_CAP_OFS);
    assign ctl_hit = (cfg_addr_i == `VCR_CTL_OFS);
    // Only the map byte lane of the control word is writable
    assign map_wr = cfg_wr_i & ctl_hit & cfg_be_i[`VCR_MAP_BE];
    assign wdata_map = cfg_wdata_i[`VCR_MAP_MSB:`VCR_MAP_LSB];

    // Fixed fields
    assign reject_snooped_traffic_flag = REJECT_SNOOP;
    assign default_channel_enable_bit = 1'b1;
    assign default_channel_identifier = `VCR_ID_VAL;
    assign class_zero_fixed_map_bit = 1'b1;
    assign full_map = {traffic_class_map_q, class_zero_fixed_map_bit};

    // Read images, all reserved bits zero
    always_comb
    begin
        cap_word = `VCR_CAP_RST;
        cap_word[`VCR_RSNP_BIT] = reject_snooped_traffic_flag;
        ctl_word = 32'h0000_0000;
        ctl_word[`VCR_EN_BIT] = default_channel_enable_bit;
        ctl_word[`VCR_ID_MSB:`VCR_ID_LSB] = default_channel_identifier;
        ctl_word[`VCR_MAP_MSB:`VCR_MAP_LSB] = traffic_class_map_q;
        ctl_word[`VCR_TC0_BIT] = class_zero_fixed_map_bit;
    end

    // Read mux; unmapped offsets answer zero
    always_comb
    begin
        if (cap_hit)
            rdata_d = cap_word;
        else if (ctl_hit)
            rdata_d = ctl_word;
        else
            rdata_d = 32'h0000_0000;
    end

    // Map register next value
    assign traffic_class_map_d = map_wr ? wdata_map : traffic_class_map_q;

    // Class map storage
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            traffic_class_map_q <= `VCR_MAP_RST;
        else
            traffic_class_map_q <= traffic_class_map_d;
    end

    // Read answer one cycle after the request
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rvalid_q <= cfg_rd_i;
            rdata_q <= cfg_rd_i ? rdata_d : 32'h0000_0000;
        end
    end

    // Hand the map and the request to the steering logic
    assign map_if.tc_map = full_map;
    assign map_if.reject_snoop = reject_snooped_traffic_flag;
    assign map_if.tlp_valid = tlp_valid_i;
    assign map_if.tlp_tc = tlp_tc_i;
    assign map_if.tlp_no_snoop = tlp_no_snoop_i;

    vcr_tc_steer u_steer
    (
        .map_if (map_if.steer)
    );

    // Registered verdict pulses and map copy
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            accept_q <= 1'b0;
            unsupp_q <= 1'b0;
            unmapped_q <= 1'b0;
            tc_map_q <= {`VCR_MAP_RST, 1'b1};
        end
        else
        begin
            accept_q <= (map_if.verdict == VCR_ACCEPT);
            unsupp_q <= (map_if.verdict == VCR_UNSUPP);
            unmapped_q <= (map_if.verdict == VCR_UNMAPPED);
            tc_map_q <= full_map;
        end
    end

    // Outputs straight from flops
    assign cfg_rvalid_o = rvalid_q;
    assign cfg_rdata_o = rdata_q;
    assign tlp_accept_o = accept_q;
    assign tlp_unsupp_o = unsupp_q;
    assign tlp_unmapped_o = unmapped_q;
    assign tc_map_o = tc_map_q;

    // Capability read shows the snoop-reject setting
    cap_snoop_read_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cfg_rd_i && cap_hit |=> cfg_rvalid_o
            && cfg_rdata_o == (REJECT_SNOOP ? 32'h0000_8000 : 32'h0000_0000))
        else $error("capability word wrong");

    // Refused snooped traffic gives an unsupported pulse and no accept pulse
    snoop_refuse_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        tlp_valid_i && REJECT_SNOOP && !tlp_no_snoop_i
            |=> tlp_unsupp_o && !tlp_accept_o)
        else $error("snooped request not refused");

    // Enable bit always reads one
    enable_fixed_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cfg_rd_i && ctl_hit |=> cfg_rdata_o[`VCR_EN_BIT])
        else $error("enable bit not set");

    // Identifier always reads zero, even after a write
    ident_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cfg_wr_i && ctl_hit ##1 cfg_rd_i && ctl_hit
            |=> cfg_rdata_o[`VCR_ID_MSB:`VCR_ID_LSB] == 3'h0)
        else $error("identifier not zero");

    // A map write is read back two cycles later
    map_write_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        map_wr ##1 (cfg_rd_i && ctl_hit && !map_wr)
            |=> cfg_rdata_o[7:1] == $past(wdata_map, 2))
        else $error("map write lost");

    // Every mapped class is accepted when snoop reject is off
    multi_class_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        tlp_valid_i && !REJECT_SNOOP && full_map[tlp_tc_i]
            |=> tlp_accept_o && !tlp_unmapped_o)
        else $error("mapped class not accepted");

    // Class zero routed whenever snoop reject is off, bit 0 always one
    class_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        tlp_valid_i && tlp_tc_i == 3'h0 && !REJECT_SNOOP
            |=> tlp_accept_o && tc_map_o[`VCR_TC0_BIT])
        else $error("class zero not routed");

    // Reserved bits read zero and ignore writes
    reserved_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cfg_rd_i && ctl_hit |=> cfg_rdata_o[30:27] == 4'h0
            && cfg_rdata_o[23:8] == 16'h0000)
        else $error("reserved bits not zero");

    // Every transaction gets exactly one verdict pulse
    verdict_single_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        tlp_valid_i |=> $onehot({tlp_accept_o, tlp_unsupp_o, tlp_unmapped_o}))
        else $error("verdict not single");

    // A class missing from the map is reported unmapped unless snooped traffic is refused
    unmapped_class_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        tlp_valid_i && !full_map[tlp_tc_i]
            && (!REJECT_SNOOP || tlp_no_snoop_i) |=> tlp_unmapped_o)
        else $error("unmapped class not reported");

    // Writes that miss the map lane leave the map alone
    map_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cfg_wr_i && (cfg_addr_i != `VCR_CTL_OFS || !cfg_be_i[`VCR_MAP_BE])
            |=> $stable(traffic_class_map_q))
        else $error("map changed by ignored write");
endmodule

//--- core/vcr_tc_steer.sv
module vcr_tc_steer
(
    vcr_map_if.steer map_if
);
    import vcr_pkg::*;

    wire snoop_refused;
    wire class_mapped;

    // Snooped traffic refused only when the capability says so
    assign snoop_refused = map_if.reject_snoop & ~map_if.tlp_no_snoop;
    // Any set map bit routes its class, many at once
    assign class_mapped = map_if.tc_map[map_if.tlp_tc];

    // Verdict, refusal takes priority over mapping
    always_comb
    begin
        if (!map_if.tlp_valid)
            map_if.verdict = VCR_NONE;
        else if (snoop_refused)
            map_if.verdict = VCR_UNSUPP;
        else if (class_mapped)
            map_if.verdict = VCR_ACCEPT;
        else
            map_if.verdict = VCR_UNMAPPED;
    end
endmodule

//--- testbench/vcr_regs_bench.sv
module vcr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vcr_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    vcr_addr_t cfg_addr_i = 12'h000;
    logic cfg_rd_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    vcr_be_t cfg_be_i = 4'h0;
    vcr_word_t cfg_wdata_i = 32'h0000_0000;
    logic cfg_rvalid_o;
    vcr_word_t cfg_rdata_o;
    logic tlp_valid_i = 1'b0;
    vcr_tc_t tlp_tc_i = 3'h0;
    logic tlp_no_snoop_i = 1'b0;
    logic tlp_accept_o, tlp_unsupp_o, tlp_unmapped_o;
    vcr_tc_map_t tc_map_o;
    vcr_word_t rej_cfg_rdata_o;
    logic rej_accept_o, rej_unsupp_o, rej_unmapped_o;
    vcr_word_t rej_seen = 32'h0000_0000;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    vcr_regs u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rvalid_o(cfg_rvalid_o), .cfg_rdata_o(cfg_rdata_o),
        .tlp_valid_i(tlp_valid_i), .tlp_tc_i(tlp_tc_i),
        .tlp_no_snoop_i(tlp_no_snoop_i), .tlp_accept_o(tlp_accept_o),
        .tlp_unsupp_o(tlp_unsupp_o), .tlp_unmapped_o(tlp_unmapped_o),
        .tc_map_o(tc_map_o));

    // Second copy with snoop reject set, sharing all inputs
    vcr_regs #(.REJECT_SNOOP(1'b1)) u_dut_rej (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_wr_i(cfg_wr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rvalid_o(), .cfg_rdata_o(rej_cfg_rdata_o),
        .tlp_valid_i(tlp_valid_i), .tlp_tc_i(tlp_tc_i),
        .tlp_no_snoop_i(tlp_no_snoop_i), .tlp_accept_o(rej_accept_o),
        .tlp_unsupp_o(rej_unsupp_o), .tlp_unmapped_o(rej_unmapped_o),
        .tc_map_o());

    // 10 MHz clock
    always #50 sys_clk_i = ~sys_clk_i;

    // Cuts a hang short
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end

    // Compares one value and reports a mismatch
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One register write; the next task lowers the strobe at the taking edge
    task automatic wr(vcr_addr_t a, vcr_be_t be, vcr_word_t d);
        @(posedge sys_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_be_i <= be;
        cfg_wdata_i <= d;
    endtask

    // One register read, answer sampled mid-cycle while it stands
    task automatic rd(vcr_addr_t a, vcr_word_t exp);
        @(posedge sys_clk_i);
        cfg_wr_i <= 1'b0;
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge sys_clk_i);
        cfg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("rvalid", {31'h0, cfg_rvalid_o}, 32'h1);
        chk("rdata", cfg_rdata_o, exp);
        rej_seen = rej_cfg_rdata_o;
    endtask

    // One transaction, verdict pulses checked while they stand
    task automatic tlp(vcr_tc_t tc, logic ns, logic [2:0] exp);
        @(posedge sys_clk_i);
        cfg_wr_i <= 1'b0;
        tlp_valid_i <= 1'b1;
        tlp_tc_i <= tc;
        tlp_no_snoop_i <= ns;
        @(posedge sys_clk_i);
        tlp_valid_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("verdict", {29'h0, tlp_accept_o, tlp_unsupp_o, tlp_unmapped_o},
            {29'h0, exp});
        // Snooped traffic is refused first on the rejecting copy
        chk("rej_verdict", {29'h0, rej_accept_o, rej_unsupp_o, rej_unmapped_o},
            {29'h0, ns ? exp : 3'b010});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        // Reset values and read-only capability
        rd(12'h110, 32'h0000_0000);
        chk("rej_cap", rej_seen, 32'h0000_8000);
        rd(12'h114, 32'h8000_00FF);
        chk("tc_map", {24'h0, tc_map_o}, 32'h0000_00FF);
        $display("test reset_values done");
        // Writes to fixed and reserved places, then a read of an unmapped offset, no traffic pending
        wr(12'h110, 4'hF, 32'hFFFF_FFFF);
        rd(12'h110, 32'h0000_0000);
        chk("rej_cap", rej_seen, 32'h0000_8000);
        wr(12'h114, 4'hE, 32'h0000_0000);
        rd(12'h114, 32'h8000_00FF);
        wr(12'h114, 4'hF, 32'h7FFF_FF02);
        rd(12'h114, 32'h8000_0003);
        rd(12'h118, 32'h0000_0000);
        $display("test read_only_bits done");
        // Several classes mapped together
        wr(12'h114, 4'h1, 32'h0000_00A4);
        rd(12'h114, 32'h8000_00A5);
        chk("tc_map", {24'h0, tc_map_o}, 32'h0000_00A5);
        for (int i = 0; i < 8; i++)
            tlp(3'(i), i[0], (8'hA5 >> i) & 1 ? 3'b100 : 3'b001);
        $display("test class_steering done");
        // Empty writable map leaves only class zero, link idle first
        wr(12'h114, 4'h1, 32'h0000_0000);
        rd(12'h114, 32'h8000_0001);
        tlp(3'h0, 1'b0, 3'b100);
        tlp(3'h7, 1'b0, 3'b001);
        $display("test class_zero done");
        complete_run();
    end
endmodule
